//--- core/rmc_core.sv
// Radio mode controller: mode sequencing, serial input buffer, receive filter
// Behaviour
// - Idle watches radio and serial sides
// - Byte count reaching threshold starts transmission
// - Threshold 1..max packet, zero disables
// - Quiet timeout with pending bytes starts transmission
// - No transmission starts while reception runs
// - Initializer first, input keeps buffering
// - Packets up to max, until buffer empty
// - Bytes left at packet end send another
// - Forward only on id, channel, address match
// - Pin sleep mode: pin high sleeps
// - Finish transfer before pin sleep
// - Pin sleep: clear-to-send high, power low
// - Modes 4..8 give 1..16 second interval
// - Listen window 35 or 225 ms
// - Data while listening receives, then sleeps
// - Cyclic sleep flags; listen sends pending
// - Wake-up initializer seen: synchronise and receive
// - Pin wake-up forces idle from cyclic
// - Transmission is initializer then payload
// - Clear-to-send off full, on 34 free
`timescale 1ns/1ps
module rmc_core
	import rmc_pkg::*;
#(
	parameter int TICKS_PER_MS = rmc_pkg::MS_CYCLES,
	parameter int DEPTH        = rmc_pkg::SIB_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sib_wr_valid,
	input  wire logic [7:0]  sib_wr_data,
	output logic             rf_tx_init,
	output logic             rf_tx_valid,
	input  wire logic        rf_tx_ready,
	output logic [7:0]       rf_tx_data,
	output logic             rf_tx_last,
	input  wire logic        rf_rx_busy,
	input  wire logic        rf_rx_init_detect,
	input  wire logic        rf_rx_valid,
	input  wire logic [7:0]  rf_rx_data,
	input  wire logic [15:0] rf_rx_net_id,
	input  wire logic [7:0]  rf_rx_channel,
	input  wire logic [15:0] rf_rx_addr,
	output logic             ser_out_valid,
	output logic [7:0]       ser_out_data,
	input  wire logic        sleep_pin,
	output logic             cts_n,
	output logic             transmit_power_indicator
);
	import rmc_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);
	localparam int PW = $clog2(DEPTH);

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	rmc_state_type   state_q;
	rmc_state_type   state_d;
	logic [7:0]      thr_q;
	logic [7:0]      maxpkt_q;
	logic [15:0]     timeout_q;
	logic [3:0]      smode_q;
	logic            pinw_q;
	logic            rate_q;
	logic [15:0]     wake_q;
	logic [15:0]     init_q;
	logic [15:0]     netid_q;
	logic [7:0]      chan_q;
	logic [15:0]     myaddr_q;
	logic [31:0]     prdata_q;
	logic [7:0]      mem_q [DEPTH];
	logic [PW-1:0]   wr_ptr_q;
	logic [PW-1:0]   rd_ptr_q;
	logic [CW-1:0]   count_q;
	logic [CW-1:0]   count_d;
	logic [7:0]      pkt_cnt_q;
	logic [31:0]     tick_cnt_q;
	logic [15:0]     quiet_q;
	logic [15:0]     idle_q;
	logic [15:0]     phase_q;
	logic            pin_s1_q;
	logic            pin_s2_q;
	logic            pin_s3_q;
	logic            sleep_lvl_q;
	logic            sleep_prev_q;
	logic            cts_n_q;
	logic            txpwr_q;
	logic            so_valid_q;
	logic [7:0]      so_data_q;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire setup      = psel & ~penable;
	wire access     = psel & penable;
	wire wr         = access & pwrite;
	wire hit_pkt    = (paddr == ADDR_PKT);
	wire hit_time   = (paddr == ADDR_TIME);
	wire hit_sleep  = (paddr == ADDR_SLEEP);
	wire hit_wake   = (paddr == ADDR_WAKE);
	wire hit_net    = (paddr == ADDR_NET);
	wire hit_addr   = (paddr == ADDR_ADDR);
	wire hit_status = (paddr == ADDR_STATUS);
	wire hit_any    = hit_pkt | hit_time | hit_sleep | hit_wake | hit_net
		| hit_addr | hit_status;

	logic [31:0] rd_mux;
	assign rd_mux =
		hit_pkt    ? {16'h0000, maxpkt_q, thr_q} :
		hit_time   ? {16'h0000, timeout_q} :
		hit_sleep  ? {23'h0, rate_q, 3'h0, pinw_q, smode_q} :
		hit_wake   ? {init_q, wake_q} :
		hit_net    ? {8'h00, chan_q, netid_q} :
		hit_addr   ? {16'h0000, myaddr_q} :
		hit_status ? {14'h0, sleep_lvl_q, cts_n_q, 8'(count_q), 1'b0, state_q} :
		32'h0000_0000;

	assign pready  = 1'b1;
	assign pslverr = access & ~hit_any;
	assign prdata  = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup & ~pwrite) begin
			prdata_q <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr_q     <= THR_RST;
			maxpkt_q  <= MAXPKT_RST;
			timeout_q <= TIMEOUT_RST;
			smode_q   <= SMODE_RST;
			pinw_q    <= 1'b0;
			rate_q    <= 1'b1;
			wake_q    <= WAKE_RST;
			init_q    <= INIT_RST;
			netid_q   <= 16'h0000;
			chan_q    <= 8'h00;
			myaddr_q  <= 16'h0000;
		end else if (wr) begin
			if (hit_pkt) begin
				thr_q    <= pwdata[PKT_THR_LSB +: 8];
				maxpkt_q <= pwdata[PKT_MAX_LSB +: 8];
			end
			if (hit_time) timeout_q <= pwdata[15:0];
			if (hit_sleep) begin
				smode_q <= pwdata[SLP_MODE_LSB +: 4];
				pinw_q  <= pwdata[SLP_PINW_BIT];
				rate_q  <= pwdata[SLP_RATE_BIT];
			end
			if (hit_wake) begin
				wake_q <= pwdata[WAKE_TIME_LSB +: 16];
				init_q <= pwdata[WAKE_INIT_LSB +: 16];
			end
			if (hit_net) begin
				netid_q <= pwdata[NET_ID_LSB +: 16];
				chan_q  <= pwdata[NET_CHAN_LSB +: 8];
			end
			if (hit_addr) myaddr_q <= pwdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// Millisecond tick and sleep pin synchroniser
	// ------------------------------------------------------------
	wire ms_tick = (tick_cnt_q == 32'(TICKS_PER_MS - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q   <= 32'h0000_0000;
			pin_s1_q     <= 1'b0;
			pin_s2_q     <= 1'b0;
			pin_s3_q     <= 1'b0;
			sleep_lvl_q  <= 1'b0;
			sleep_prev_q <= 1'b0;
		end else begin
			tick_cnt_q   <= ms_tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
			pin_s1_q     <= sleep_pin;
			pin_s2_q     <= pin_s1_q;
			pin_s3_q     <= pin_s2_q;
			sleep_prev_q <= sleep_lvl_q;
			if (pin_s2_q == pin_s3_q) sleep_lvl_q <= pin_s3_q;
		end
	end

	wire sleep_fall = sleep_prev_q & ~sleep_lvl_q;

	// ------------------------------------------------------------
	// Serial input buffer
	// ------------------------------------------------------------
	wire full = (count_q == CW'(DEPTH));
	wire push = sib_wr_valid & ~full;
	wire pop  = rf_tx_valid & rf_tx_ready;

	assign count_d = count_q + CW'(push) - CW'(pop);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) wr_ptr_q <= wr_ptr_q + PW'(1);
			if (pop) rd_ptr_q <= rd_ptr_q + PW'(1);
			count_q <= count_d;
		end
	end

	always_ff @(posedge pclk) begin
		if (push) mem_q[wr_ptr_q] <= sib_wr_data;
	end

	// ------------------------------------------------------------
	// Triggers and mode decode
	// ------------------------------------------------------------
	wire [7:0] max_eff = (maxpkt_q == 8'h00) ? 8'h01 : maxpkt_q;
	wire [7:0] thr_eff = (thr_q > max_eff) ? max_eff : thr_q;
	wire thr_trig  = (thr_q != 8'h00) && (32'(count_q) >= 32'(thr_eff));
	wire to_trig   = (timeout_q != 16'h0000) && (count_q != '0)
		&& (quiet_q >= timeout_q);
	wire tx_trig   = thr_trig | to_trig;
	wire rx_act    = rf_rx_busy | rf_rx_init_detect;
	wire cyc_mode  = (smode_q >= SM_CYC_MIN) && (smode_q <= SM_CYC_MAX);
	wire pin_mode  = (smode_q == SM_PIN);
	wire pin_req   = pin_mode & sleep_lvl_q;
	wire [15:0] cyc_ms = 16'(CYC_BASE_MS) << (smode_q - SM_CYC_MIN);
	wire [15:0] lsn_ms = rate_q ? 16'(LISTEN_RATE1_MS) : 16'(LISTEN_RATE0_MS);
	wire [15:0] init_ms = (init_q == 16'h0000) ? 16'h0001 : init_q;
	wire pkt_end   = (pkt_cnt_q == max_eff - 8'h01) || (count_q == CW'(1));
	wire sleeping  = (state_q == ST_PSLP) || (state_q == ST_CSLP);

	// ------------------------------------------------------------
	// Mode sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (rx_act) begin
					state_d = ST_RX;
				end else if (tx_trig) begin
					state_d = ST_TXI;
				end else if (pin_req) begin
					state_d = ST_PSLP;
				end else if (cyc_mode && idle_q >= wake_q) begin
					state_d = ST_CSLP;
				end
			end
			ST_TXI: begin
				if (phase_q >= init_ms) state_d = ST_TXD;
			end
			ST_TXD: begin
				if (pop && pkt_end && count_d == '0) state_d = ST_IDLE;
			end
			ST_RX: begin
				if (!rx_act) state_d = ST_IDLE;
			end
			ST_PSLP: begin
				if (!pin_req) state_d = ST_IDLE;
			end
			ST_CSLP: begin
				if (!cyc_mode) begin
					state_d = ST_IDLE;
				end else if (pinw_q && sleep_fall) begin
					state_d = ST_IDLE;
				end else if (phase_q >= cyc_ms) begin
					state_d = ST_LSN;
				end
			end
			ST_LSN: begin
				if (rx_act) begin
					state_d = ST_RX;
				end else if (count_q != '0) begin
					state_d = ST_TXI;
				end else if (!cyc_mode) begin
					state_d = ST_IDLE;
				end else if (phase_q >= lsn_ms) begin
					state_d = ST_CSLP;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			phase_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			if (state_d != state_q) phase_q <= 16'h0000;
			else if (ms_tick) phase_q <= sat_inc(phase_q);
		end
	end

	// ------------------------------------------------------------
	// Quiet and inactivity timers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_q <= 16'h0000;
			idle_q  <= 16'h0000;
		end else begin
			if (sib_wr_valid) quiet_q <= 16'h0000;
			else if (ms_tick) quiet_q <= sat_inc(quiet_q);
			if (state_q != ST_IDLE || sib_wr_valid || rx_act) idle_q <= 16'h0000;
			else if (ms_tick) idle_q <= sat_inc(idle_q);
		end
	end

	// ------------------------------------------------------------
	// Transmit path
	// ------------------------------------------------------------
	assign rf_tx_init  = (state_q == ST_TXI);
	assign rf_tx_valid = (state_q == ST_TXD) && (count_q != '0);
	assign rf_tx_data  = mem_q[rd_ptr_q];
	assign rf_tx_last  = rf_tx_valid & pkt_end;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pkt_cnt_q <= 8'h00;
		end else if (state_q != ST_TXD) begin
			pkt_cnt_q <= 8'h00;
		end else if (pop) begin
			pkt_cnt_q <= pkt_end ? 8'h00 : pkt_cnt_q + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Receive filter
	// ------------------------------------------------------------
	wire rx_match = (rf_rx_net_id == netid_q) && (rf_rx_channel == chan_q)
		&& (rf_rx_addr == myaddr_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			so_valid_q <= 1'b0;
			so_data_q  <= 8'h00;
		end else begin
			so_valid_q <= rf_rx_valid & rx_match & ~sleeping;
			if (rf_rx_valid & rx_match) so_data_q <= rf_rx_data;
		end
	end

	assign ser_out_valid = so_valid_q;
	assign ser_out_data  = so_data_q;

	// ------------------------------------------------------------
	// Flow control and power indicator
	// ------------------------------------------------------------
	wire [CW-1:0] free_d = CW'(DEPTH) - count_d;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cts_n_q <= 1'b0;
			txpwr_q <= 1'b1;
		end else begin
			if (state_d == ST_PSLP || state_d == ST_CSLP) begin
				cts_n_q <= 1'b1;
			end else if (count_d == CW'(DEPTH)) begin
				cts_n_q <= 1'b1;
			end else if (free_d >= CW'(CTS_RESUME_FREE)) begin
				cts_n_q <= 1'b0;
			end
			txpwr_q <= ~(state_d == ST_PSLP || state_d == ST_CSLP);
		end
	end

	assign cts_n                    = cts_n_q;
	assign transmit_power_indicator = txpwr_q;

endmodule

//--- shared/rmc_pkg.sv
// Shared constants and types of the radio mode controller
package rmc_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 8;
	localparam int MS_NS            = 1_000_000;
	localparam int MS_CYCLES        = MS_NS / CLK_PERIOD_NS;
	localparam int LISTEN_RATE1_MS  = 35;
	localparam int LISTEN_RATE0_MS  = 225;
	localparam int CYC_BASE_MS      = 1000;
	localparam int CTS_RESUME_FREE  = 34;
	localparam int SIB_DEPTH        = 64;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PKT    = 8'h00;
	localparam logic [7:0] ADDR_TIME   = 8'h04;
	localparam logic [7:0] ADDR_SLEEP  = 8'h08;
	localparam logic [7:0] ADDR_WAKE   = 8'h0C;
	localparam logic [7:0] ADDR_NET    = 8'h10;
	localparam logic [7:0] ADDR_ADDR   = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int PKT_THR_LSB   = 0;
	localparam int PKT_MAX_LSB   = 8;
	localparam int SLP_MODE_LSB  = 0;
	localparam int SLP_PINW_BIT  = 4;
	localparam int SLP_RATE_BIT  = 8;
	localparam int WAKE_TIME_LSB = 0;
	localparam int WAKE_INIT_LSB = 16;
	localparam int NET_ID_LSB    = 0;
	localparam int NET_CHAN_LSB  = 16;
	localparam int STS_STATE_LSB = 0;
	localparam int STS_COUNT_LSB = 8;
	localparam int STS_CTS_BIT   = 16;
	localparam int STS_PIN_BIT   = 17;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  THR_RST     = 8'h40;
	localparam logic [7:0]  MAXPKT_RST  = 8'h40;
	localparam logic [15:0] TIMEOUT_RST = 16'h0003;
	localparam logic [3:0]  SMODE_RST   = 4'h0;
	localparam logic [15:0] WAKE_RST    = 16'h0BB8;
	localparam logic [15:0] INIT_RST    = 16'h0064;

	// ------------------------------------------------------------
	// Sleep mode codes and states
	// ------------------------------------------------------------
	localparam logic [3:0] SM_PIN     = 4'h1;
	localparam logic [3:0] SM_CYC_MIN = 4'h4;
	localparam logic [3:0] SM_CYC_MAX = 4'h8;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001,
		ST_TXI  = 7'b000_0010,
		ST_TXD  = 7'b000_0100,
		ST_RX   = 7'b000_1000,
		ST_PSLP = 7'b001_0000,
		ST_CSLP = 7'b010_0000,
		ST_LSN  = 7'b100_0000
	} rmc_state_type;

endpackage

//--- verif/rmc_core_props.sv
// Port checker of the radio mode controller
`timescale 1ns/1ps
module rmc_core_props (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       rf_tx_init,
	input wire logic       rf_tx_valid,
	input wire logic       rf_tx_ready,
	input wire logic [7:0] rf_tx_data,
	input wire logic       rf_tx_last,
	input wire logic       rf_rx_busy,
	input wire logic       rf_rx_init_detect,
	input wire logic       rf_rx_valid,
	input wire logic [7:0] rf_rx_data,
	input wire logic       ser_out_valid,
	input wire logic [7:0] ser_out_data,
	input wire logic       cts_n,
	input wire logic       transmit_power_indicator
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----
	// Transmit path
	// ----
	AST_NO_TX_IN_RX: assert property ($rose(rf_tx_init) |-> !$past(rf_tx_init)
		&& !$past(rf_rx_busy) && !$past(rf_rx_init_detect)) else $error("tx during rx");
	AST_INIT_THEN_DATA: assert property ($rose(rf_tx_valid) |-> $past(rf_tx_init))
		else $error("payload without initializer");
	AST_INIT_DATA_APART: assert property (!(rf_tx_init && rf_tx_valid))
		else $error("payload during initializer");
	AST_HOLD_BYTE: assert property (rf_tx_valid && !rf_tx_ready |=> rf_tx_valid
		&& $stable(rf_tx_data)) else $error("byte dropped while stalled");
	AST_LAST_IN_BYTE: assert property (rf_tx_last |-> rf_tx_valid)
		else $error("packet end without byte");

	// ----
	// Receive and sleep
	// ----
	AST_FORWARD: assert property (ser_out_valid |-> $past(rf_rx_valid)
		&& ser_out_data == $past(rf_rx_data)) else $error("forward without received byte");
	AST_SLEEP_CTS: assert property (!transmit_power_indicator |-> cts_n)
		else $error("clear to send while asleep");
	AST_SLEEP_AFTER_TX: assert property ($fell(transmit_power_indicator)
		|-> !$past(rf_tx_valid) && !$past(rf_tx_init)) else $error("sleep cut transfer");
	AST_SLEEP_SILENT: assert property (!transmit_power_indicator
		|-> !rf_tx_valid && !rf_tx_init) else $error("transmit while asleep");
	AST_WAKE_CTS: assert property ($rose(transmit_power_indicator) |-> !cts_n)
		else $error("no clear to send on wake");
	COV_LAST: cover property ($rose(rf_tx_last));
	COV_SLEEP: cover property ($fell(transmit_power_indicator));
	COV_FWD: cover property (ser_out_valid);
endmodule

bind rmc_core rmc_core_props chk_u (.pclk(pclk), .presetn(presetn),
	.rf_tx_init(rf_tx_init), .rf_tx_valid(rf_tx_valid), .rf_tx_ready(rf_tx_ready),
	.rf_tx_data(rf_tx_data), .rf_tx_last(rf_tx_last), .rf_rx_busy(rf_rx_busy),
	.rf_rx_init_detect(rf_rx_init_detect), .rf_rx_valid(rf_rx_valid),
	.rf_rx_data(rf_rx_data), .ser_out_valid(ser_out_valid), .ser_out_data(ser_out_data),
	.cts_n(cts_n), .transmit_power_indicator(transmit_power_indicator));

//--- verif/rmc_host.sv
// Host model: serial bytes under flow control, sleep pin
`timescale 1ns/1ps
module rmc_host (
	input  wire logic       pclk,
	input  wire logic       cts_n,
	input  wire logic       rf_tx_init,
	output logic            sib_wr_valid,
	output logic [7:0]      sib_wr_data,
	output logic            sleep_pin
);
	int lost;
	initial begin
		sib_wr_valid = 1'b0;
		sib_wr_data  = 8'h00;
		sleep_pin    = 1'b0;
		lost         = 0;
	end
	// Bytes base.. one per cycle, only while clear to send
	task automatic send(input int n, input logic [7:0] base);
		int i;
		int w;
		i = 0;
		w = 0;
		while (i < n && w < 4000) begin
			@(posedge pclk);
			w++;
			if (!cts_n) begin
				sib_wr_valid <= 1'b1;
				sib_wr_data  <= base + 8'(i);
				i++;
			end else begin
				sib_wr_valid <= 1'b0;
				sib_wr_data  <= ~sib_wr_data;
			end
		end
		@(posedge pclk);
		sib_wr_valid <= 1'b0;
		sib_wr_data  <= ~sib_wr_data;
		lost += n - i;
	endtask
	// Pin change waits until the initializer is over, then two cycles
	task automatic sleep(input logic v);
		int w;
		w = 0;
		while (rf_tx_init && w < 4000) begin
			@(posedge pclk);
			w++;
		end
		repeat (2) @(posedge pclk);
		sleep_pin <= v;
	endtask
endmodule

//--- verif/test_radio_mode_controller.sv
// Self-checking bench of the radio mode controller
`timescale 1ns/1ps
module test_radio_mode_controller;
	import rmc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sib_wr_valid;
	logic [7:0]  paddr, sib_wr_data, rf_tx_data, rf_rx_data, rf_rx_channel, ser_out_data;
	logic [31:0] pwdata, prdata;
	logic [15:0] rf_rx_net_id, rf_rx_addr;
	logic        rf_tx_init, rf_tx_valid, rf_tx_ready, rf_tx_last, rf_rx_busy, cts_n;
	logic        rf_rx_init_detect, rf_rx_valid, ser_out_valid, sleep_pin, transmit_power_indicator;
	logic [8:0]  txq[$];
	int          num_errors, cmp_count, cyc, t0;

	rmc_core #(.TICKS_PER_MS(10), .DEPTH(64)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sib_wr_valid(sib_wr_valid), .sib_wr_data(sib_wr_data), .rf_tx_init(rf_tx_init),
		.rf_tx_valid(rf_tx_valid), .rf_tx_ready(rf_tx_ready), .rf_tx_data(rf_tx_data),
		.rf_tx_last(rf_tx_last), .rf_rx_busy(rf_rx_busy), .rf_rx_init_detect(rf_rx_init_detect),
		.rf_rx_valid(rf_rx_valid), .rf_rx_data(rf_rx_data), .rf_rx_net_id(rf_rx_net_id),
		.rf_rx_channel(rf_rx_channel), .rf_rx_addr(rf_rx_addr), .ser_out_valid(ser_out_valid),
		.ser_out_data(ser_out_data), .sleep_pin(sleep_pin), .cts_n(cts_n),
		.transmit_power_indicator(transmit_power_indicator));
	rmc_host host_u (.pclk(pclk), .cts_n(cts_n), .rf_tx_init(rf_tx_init),
		.sib_wr_valid(sib_wr_valid), .sib_wr_data(sib_wr_data), .sleep_pin(sleep_pin));

	// ----
	// Clock, radio sink with stalls, shared tasks
	// ----
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (rf_tx_valid && rf_tx_ready) txq.push_back({rf_tx_last, rf_tx_data});
		rf_tx_ready <= ~rf_tx_ready;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		if (pready !== 1'b1) chk(32'h0, 32'h1, "apb hang");
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x, s);
	endtask
	task automatic wait_st(input rmc_state_type s, input int lim);
		logic [31:0] r;
		logic        e;
		int          n;
		n = 0;
		do begin
			apb(1'b0, ADDR_STATUS, 32'h0, r, e);
			n++;
		end while (r[6:0] !== s && n < lim);
		chk(32'(r[6:0]), 32'(s), "state");
	endtask
	task automatic flags(input logic [1:0] x);
		#1;
		chk(32'({cts_n, transmit_power_indicator}), 32'(x), "sleep flags");
	endtask
	task automatic rng(input int d, input int lo, input int hi);
		chk(32'(d >= lo && d <= hi), 32'h1, "duration");
	endtask
	task automatic expect_tx(input int n, input int mx, input logic [7:0] base);
		int   i;
		int   w;
		logic l;
		w = 0;
		while (txq.size() < n && w < 3000) begin
			@(posedge pclk);
			w++;
		end
		chk(32'(txq.size()), 32'(n), "tx count");
		for (i = 0; i < n; i++) begin
			l = (i % mx == mx - 1) || (i == n - 1);
			chk(32'(txq[i]), 32'({l, base + 8'(i)}), "tx byte");
		end
		txq.delete();
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		logic [31:0] r;
		logic        e;
		rd(ADDR_PKT, 32'h0000_4040, "pkt");
		rd(ADDR_TIME, 32'h0000_0003, "time");
		rd(ADDR_SLEEP, 32'h0000_0100, "sleep");
		rd(ADDR_WAKE, 32'h0064_0BB8, "wake");
		rd(ADDR_STATUS, 32'h0000_0001, "idle");
		apb(1'b0, 8'h1C, 32'h0, r, e);
		chk(r, 32'h0, "unmapped data");
		chk(32'(e), 32'h1, "unmapped error");
		$display("register test done");
	endtask
	task automatic t_pkt;
		wr(ADDR_PKT, 32'h0000_0404);
		wr(ADDR_TIME, 32'h0000_0000);
		wr(ADDR_WAKE, 32'h0001_0BB8);
		host_u.send(3, 8'h10);
		repeat (40) @(posedge pclk);
		rd(ADDR_STATUS, 32'h0000_0301, "below threshold");
		host_u.send(3, 8'h13);
		expect_tx(6, 4, 8'h10);
		wr(ADDR_PKT, 32'h0000_0300);
		wr(ADDR_TIME, 32'h0000_0002);
		host_u.send(7, 8'h40);
		rd(ADDR_STATUS, 32'h0000_0701, "quiet wait");
		expect_tx(7, 3, 8'h40);
		$display("packet test done");
	endtask
	task automatic t_rx;
		int k;
		wr(ADDR_PKT, 32'h0000_0402);
		wr(ADDR_NET, 32'h0005_1234);
		wr(ADDR_ADDR, 32'h0000_00AB);
		rf_rx_busy <= 1'b1;
		host_u.send(2, 8'h60);
		for (k = 0; k < 4; k++) begin
			@(posedge pclk);
			rf_rx_valid   <= 1'b1;
			rf_rx_data    <= 8'hC0 + 8'(k);
			rf_rx_net_id  <= (k == 1) ? 16'h1235 : 16'h1234;
			rf_rx_channel <= (k == 2) ? 8'h06 : 8'h05;
			rf_rx_addr    <= (k == 3) ? 16'h00AC : 16'h00AB;
			@(posedge pclk);
			rf_rx_valid <= 1'b0;
			rf_rx_data  <= ~rf_rx_data;
			#1;
			chk(32'({ser_out_valid, ser_out_valid ? ser_out_data : 8'h00}),
				(k == 0) ? 32'h0000_01C0 : 32'h0, "forward");
		end
		rd(ADDR_STATUS, 32'h0000_0208, "tx held");
		rf_rx_busy <= 1'b0;
		expect_tx(2, 4, 8'h60);
		$display("receive test done");
	endtask
	task automatic t_full;
		wr(ADDR_PKT, 32'h0000_0400);
		wr(ADDR_TIME, 32'h0000_0000);
		fork
			host_u.send(70, 8'h00);
		join_none
		repeat (150) @(posedge pclk);
		rd(ADDR_STATUS, 32'h0001_4001, "full");
		wr(ADDR_PKT, 32'h0000_0401);
		wait fork;
		wait_st(ST_IDLE, 400);
		rd(ADDR_STATUS, 32'h0000_0001, "drained");
		txq.delete();
		$display("full buffer test done");
	endtask
	task automatic t_pin;
		host_u.sleep(1'b1);
		repeat (6) @(posedge pclk);
		rd(ADDR_STATUS, 32'h0002_0001, "pin ignored");
		wr(ADDR_SLEEP, 32'h0000_0101);
		wait_st(ST_PSLP, 10);
		flags(2'b10);
		host_u.sleep(1'b0);
		wait_st(ST_IDLE, 10);
		flags(2'b01);
		host_u.send(3, 8'h70);
		host_u.sleep(1'b1);
		expect_tx(3, 4, 8'h70);
		wait_st(ST_PSLP, 10);
		host_u.sleep(1'b0);
		wait_st(ST_IDLE, 10);
		$display("pin sleep test done");
	endtask
	task automatic t_cyc;
		wr(ADDR_WAKE, 32'h07D0_0001);
		wr(ADDR_SLEEP, 32'h0000_0114);
		wait_st(ST_CSLP, 20);
		flags(2'b10);
		t0 = cyc;
		wait_st(ST_LSN, 4000);
		flags(2'b01);
		rng(cyc - t0, 9990, 10010);
		rf_rx_init_detect <= 1'b1;
		wait_st(ST_RX, 10);
		rf_rx_init_detect <= 1'b0;
		wait_st(ST_CSLP, 40);
		wait_st(ST_LSN, 4000);
		t0 = cyc;
		wait_st(ST_CSLP, 200);
		rng(cyc - t0, 340, 360);
		wr(ADDR_SLEEP, 32'h0000_0014);
		wait_st(ST_LSN, 4000);
		t0 = cyc;
		wait_st(ST_CSLP, 1000);
		rng(cyc - t0, 2240, 2260);
		host_u.sleep(1'b1);
		repeat (6) @(posedge pclk);
		host_u.sleep(1'b0);
		wait_st(ST_IDLE, 10);
		wait_st(ST_CSLP, 20);
		$display("cyclic sleep test done");
	endtask

	initial begin
		presetn           = 1'b0;
		psel              = 1'b0;
		penable           = 1'b0;
		pwrite            = 1'b0;
		paddr             = 8'h00;
		pwdata            = 32'h0000_0000;
		rf_tx_ready       = 1'b0;
		rf_rx_busy        = 1'b0;
		rf_rx_init_detect = 1'b0;
		rf_rx_valid       = 1'b0;
		rf_rx_data        = 8'h00;
		rf_rx_net_id      = 16'h0000;
		rf_rx_channel     = 8'h00;
		rf_rx_addr        = 16'h0000;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_pkt();
		t_rx();
		t_full();
		t_pin();
		t_cyc();
		chk(32'(host_u.lost), 32'h0, "host stalled");
		close_out();
	end
endmodule
